/* File: shared/sao_consts.vh */
// constants for the safing arm output and disposal block
`ifndef SAO_CONSTS_VH
`define SAO_CONSTS_VH
// ==========================================================
// apb register byte offsets
`define SAO_OFF_REC_EN      12'h000
`define SAO_OFF_REC_MAP     12'h004
`define SAO_OFF_REC_DWELL0  12'h008
`define SAO_OFF_REC_DWELL1  12'h00C
`define SAO_OFF_REC_ARMED   12'h010
`define SAO_OFF_LOOP_MASK   12'h014
`define SAO_OFF_DIAG        12'h018
`define SAO_OFF_STRETCH     12'h01C
`define SAO_OFF_SEED        12'h020
`define SAO_OFF_KEY         12'h024
`define SAO_OFF_DISP_STAT   12'h028
// ==========================================================
// sizes and field positions
`define SAO_NREC            4
`define SAO_NARM            4
`define SAO_NLOOP           4
`define SAO_DWELL_W         8
`define SAO_KEY_XOR         8'h55
`define SAO_DIAG_ARM_BIT    0
`define SAO_DIAG_RAIL_BIT   1
`define SAO_DIAG_MODE_BIT   2
`define SAO_DIAG_FET_BIT    3
// ==========================================================
// timing defaults in cycles of the 8 ns clock
`define SAO_SEED_DIV        16'h0100
`define SAO_TIMEOUT_CYC     32'h00BE_BC20
`define SAO_PER_MIN         24'h00_1000
`define SAO_PER_MAX         24'h00_4000
`define SAO_ON_MIN          24'h00_0800
`define SAO_ON_MAX          24'h00_2000
`define SAO_ACL_NEED        2'h3
`define SAO_ACL_BAD_LIM     2'h2
`endif

/* File: logic/sao_top.v */
// safing arm output stage with disposal arming handshake
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "sao_consts.vh"
// How it works
// [RL1] arm line is OR of enabled armed records
// [RL2] per-loop mask gates arm lines to drivers
// [RL3] arm line enables rail; fet needs host
// [RL4] four arm output pins show arming state
// [RL5] arm-pin and rail tests never together
// [RL6] dwell runs on; safing reset truncates it
// [RL7] one counter per output; longest dwell wins
// [RL8] reload only when remaining count smaller
// [RL9] free 8-bit seed counter readable by host
// [RL10] seed read freezes seed, computes key
// [RL11] key is seed XOR 0x55
// [RL12] two handshakes plus valid line to arm
// [RL13] host refreshes correct key before timeout
// [RL14] disposal arming drives all outputs, rail
// [RL15] bad, late key or line drops to standby
// [RL16] line period/duty checked; three cycles needed
// [RL17] two consecutive bad cycles disqualify line
// [RL18] missing line: stay standby or leave arming
// [RL19] stretch timer states readable in status
// [RL20] safing reset clears all records
// [RL21] line limits, timeout, seed rate are parameters
module sao_top #(
  parameter [15:0] SEED_DIV    = `SAO_SEED_DIV,  // RL21
  parameter [31:0] TIMEOUT_CYC = `SAO_TIMEOUT_CYC,
  parameter [23:0] PER_MIN     = `SAO_PER_MIN,
  parameter [23:0] PER_MAX     = `SAO_PER_MAX,
  parameter [23:0] ON_MIN      = `SAO_ON_MIN,
  parameter [23:0] ON_MAX      = `SAO_ON_MAX
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // safing side
  input  wire        safing_reset_n,
  input  wire [3:0]  record_armed,
  input  wire        host_fet_req,
  input  wire        disposal_line,
  // outputs
  output reg  [3:0]  arm_output_pin,
  output reg         safing_fet_rail,
  output reg         safing_fet_on,
  output reg  [15:0] loop_enable,
  output reg         disposal_arming
);
  localparam NR = `SAO_NREC;
  localparam NA = `SAO_NARM;
  localparam DW = `SAO_DWELL_W;
  localparam [1:0] ST_STBY = 2'b01;
  localparam [1:0] ST_ARM  = 2'b10;

  // ==========================================================
  // registers
  reg  [NR-1:0]   rec_en_r;
  reg  [2*NR-1:0] rec_map_r;
  reg  [4*DW-1:0] rec_dwell_r;
  reg  [4*NA-1:0] loop_mask_r;
  reg  [3:0]      diag_r;
  reg  [7:0]      seed_cnt_r;
  reg  [15:0]     seed_div_r;
  reg  [7:0]      exp_key_r;
  reg             key_armed_r;
  reg  [1:0]      hs_cnt_r;
  reg  [1:0]      st_r;
  reg  [31:0]     tmo_r;
  reg  [31:0]     rd_mux;
  wire [NA*DW-1:0] dwell_cnt;
  wire [NA-1:0]   arm_int;
  wire            wr = psel & penable & pwrite;
  wire            rd = psel & penable & ~pwrite;
  wire            key_wr = wr & (paddr == `SAO_OFF_KEY);
  // in arming the refresh key is checked against the last frozen seed
  wire            key_ok = key_wr & (key_armed_r | (st_r == ST_ARM)) & (pwdata[7:0] == exp_key_r);
  wire            acl_ok;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================
  // register writes
  always @(posedge core_clk)
  begin
    if (!rstn || !safing_reset_n)
    begin
      rec_en_r    <= {NR{1'b0}};  // RL20
      rec_map_r   <= {2*NR{1'b0}};
      rec_dwell_r <= {4*DW{1'b0}};
      loop_mask_r <= {4*NA{1'b0}};
      diag_r      <= 4'h0;
    end
    else if (wr)
    begin
      case (paddr)
        `SAO_OFF_REC_EN:     rec_en_r    <= pwdata[NR-1:0];
        `SAO_OFF_REC_MAP:    rec_map_r   <= pwdata[2*NR-1:0];
        `SAO_OFF_REC_DWELL0: rec_dwell_r <= {rec_dwell_r[4*DW-1:2*DW], pwdata[2*DW-1:0]};
        `SAO_OFF_REC_DWELL1: rec_dwell_r <= {pwdata[2*DW-1:0], rec_dwell_r[2*DW-1:0]};
        `SAO_OFF_LOOP_MASK:  loop_mask_r <= pwdata[4*NA-1:0];
        `SAO_OFF_DIAG:
        begin
          diag_r <= pwdata[3:0];
          if (pwdata[`SAO_DIAG_ARM_BIT] && pwdata[`SAO_DIAG_RAIL_BIT])
            diag_r[`SAO_DIAG_RAIL_BIT] <= 1'b0;  // RL5
        end
        default: diag_r <= diag_r;
      endcase
    end
  end

  // ==========================================================
  // arm lines and dwell counters, one per output
  genvar a;
  generate
    for (a = 0; a < NA; a = a + 1)
    begin : g_arm
      reg [DW-1:0] longest;
      reg          hit;
      integer      r;
      always @*
      begin
        longest = {DW{1'b0}};
        hit     = 1'b0;
        for (r = 0; r < NR; r = r + 1)
          if (rec_en_r[r] && record_armed[r] && rec_map_r[2*r +: 2] == a)
          begin
            hit = 1'b1;  // RL1
            if (rec_dwell_r[DW*r +: DW] > longest)
              longest = rec_dwell_r[DW*r +: DW];  // RL7
          end
      end
      reg [DW-1:0] cnt_r;
      always @(posedge core_clk)
      begin
        if (!rstn || !safing_reset_n)
          cnt_r <= {DW{1'b0}};  // RL6
        else if (hit && cnt_r < longest)
          cnt_r <= longest;  // RL8
        else if (cnt_r != {DW{1'b0}})
          cnt_r <= cnt_r - 1'b1;  // RL6
      end
      assign dwell_cnt[DW*a +: DW] = cnt_r;
      assign arm_int[a]            = hit | (cnt_r != {DW{1'b0}});
    end
  endgenerate

  // ==========================================================
  // seed counter and key
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      seed_div_r <= 16'h0000;
      seed_cnt_r <= 8'h00;
    end
    else if (seed_div_r >= SEED_DIV - 16'h0001)
    begin
      seed_div_r <= 16'h0000;
      seed_cnt_r <= seed_cnt_r + 8'h01;  // RL9
    end
    else
      seed_div_r <= seed_div_r + 16'h0001;
  end

  // ==========================================================
  // disposal line qualification
  reg  [23:0] per_r;
  reg  [23:0] on_r;
  reg         acl_d_r;
  reg  [1:0]  good_r;
  reg  [1:0]  bad_r;
  wire        rise = disposal_line & ~acl_d_r;
  wire        cyc_ok = (per_r >= PER_MIN) && (per_r <= PER_MAX) && (on_r >= ON_MIN) && (on_r <= ON_MAX);
  wire        stuck = per_r > PER_MAX;
  assign acl_ok = (good_r == `SAO_ACL_NEED);
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      acl_d_r <= 1'b0;
      per_r   <= 24'h000000;
      on_r    <= 24'h000000;
      good_r  <= 2'h0;
      bad_r   <= 2'h0;
    end
    else
    begin
      acl_d_r <= disposal_line;
      if (rise || stuck)
      begin
        per_r <= 24'h000001;
        on_r  <= {23'h000000, disposal_line};
        if (cyc_ok && !stuck)  // RL16
        begin
          bad_r <= 2'h0;
          if (good_r != `SAO_ACL_NEED)
            good_r <= good_r + 2'h1;
        end
        else if (bad_r + 2'h1 >= `SAO_ACL_BAD_LIM)
        begin
          bad_r  <= 2'h0;
          good_r <= 2'h0;  // RL17
        end
        else
          bad_r <= bad_r + 2'h1;
      end
      else
      begin
        per_r <= per_r + 24'h000001;
        if (disposal_line)
          on_r <= on_r + 24'h000001;
      end
    end
  end

  // ==========================================================
  // disposal handshake state machine
  always @(posedge core_clk)
  begin
    if (!rstn || !safing_reset_n)
    begin
      st_r        <= ST_STBY;
      exp_key_r   <= 8'h00;
      key_armed_r <= 1'b0;
      hs_cnt_r    <= 2'h0;
      tmo_r       <= 32'h0;
    end
    else
    begin
      if (rd && paddr == `SAO_OFF_SEED)
      begin
        // the key follows the seed value the host was actually shown
        exp_key_r   <= prdata[7:0] ^ `SAO_KEY_XOR;  // RL10 RL11
        key_armed_r <= 1'b1;
      end
      else if (key_wr)
        key_armed_r <= 1'b0;
      case (st_r)
        ST_STBY:
        begin
          tmo_r <= 32'h0;
          if (key_wr)
            hs_cnt_r <= key_ok ? ((hs_cnt_r == 2'h2) ? 2'h2 : hs_cnt_r + 2'h1) : 2'h0;
          if (hs_cnt_r == 2'h2 && acl_ok)  // RL12 RL18
          begin
            st_r     <= ST_ARM;
            hs_cnt_r <= 2'h0;
          end
        end
        ST_ARM:
        begin
          // RL13 RL15
          if ((key_wr && !key_ok) || !acl_ok || tmo_r >= TIMEOUT_CYC - 32'h1)
          begin
            st_r <= ST_STBY;  // RL18
            tmo_r <= 32'h0;
          end
          else
            tmo_r <= key_ok ? 32'h0 : tmo_r + 32'h1;
        end
        default: st_r <= ST_STBY;
      endcase
    end
  end

  // ==========================================================
  // output stage
  integer l;
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      arm_output_pin  <= 4'h0;
      safing_fet_rail <= 1'b0;
      safing_fet_on   <= 1'b0;
      loop_enable     <= 16'h0000;
      disposal_arming <= 1'b0;
    end
    else
    begin
      disposal_arming <= (st_r == ST_ARM);
      if (st_r == ST_ARM)
      begin
        arm_output_pin  <= 4'hF;  // RL14
        safing_fet_rail <= 1'b1;
      end
      else if (diag_r[`SAO_DIAG_MODE_BIT])
      begin
        arm_output_pin  <= {NA{diag_r[`SAO_DIAG_ARM_BIT]}};  // RL5
        safing_fet_rail <= diag_r[`SAO_DIAG_RAIL_BIT] & ~diag_r[`SAO_DIAG_ARM_BIT];
      end
      else
      begin
        arm_output_pin  <= arm_int;  // RL4
        safing_fet_rail <= |arm_int;  // RL3
      end
      safing_fet_on <= safing_fet_rail & host_fet_req;  // RL3
      for (l = 0; l < `SAO_NLOOP; l = l + 1)
        loop_enable[4*l +: 4] <= (st_r == ST_ARM) ? 4'hF : (arm_int & ~loop_mask_r[4*l +: 4]);  // RL2
    end
  end

  // ==========================================================
  // read mux
  always @*
  begin
    case (paddr)
      `SAO_OFF_REC_EN:     rd_mux = {28'h0, rec_en_r};
      `SAO_OFF_REC_MAP:    rd_mux = {24'h0, rec_map_r};
      `SAO_OFF_REC_DWELL0: rd_mux = {16'h0, rec_dwell_r[15:0]};
      `SAO_OFF_REC_DWELL1: rd_mux = {16'h0, rec_dwell_r[31:16]};
      `SAO_OFF_REC_ARMED:  rd_mux = {28'h0, record_armed};
      `SAO_OFF_LOOP_MASK:  rd_mux = {16'h0, loop_mask_r};
      `SAO_OFF_DIAG:       rd_mux = {28'h0, diag_r};
      `SAO_OFF_STRETCH:    rd_mux = dwell_cnt;  // RL19
      `SAO_OFF_SEED:       rd_mux = {24'h0, seed_cnt_r};  // RL9
      `SAO_OFF_DISP_STAT:  rd_mux = {24'h0, good_r, hs_cnt_r, 2'h0, key_armed_r, st_r == ST_ARM};
      default:             rd_mux = 32'h0;
    endcase
  end

  // ==========================================================
  // read data register, loaded in the setup cycle so that it
  // stands unchanged through the access cycle
  always @(posedge core_clk)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rd_mux;
  end
endmodule // sao_top

/* File: sim/sao_props.sv */
// assertions on the safing arm output block ports
`timescale 1ns/1ps
module sao_props #(
  parameter [31:0] TIMEOUT_CYC = 32'hC8,
  parameter [23:0] PER_MAX     = 24'h20
) (
  // clock and reset
  input wire        core_clk,
  input wire        rstn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  // safing side
  input wire        safing_reset_n,
  input wire        host_fet_req,
  input wire        disposal_line,
  // outputs
  input wire [3:0]  arm_output_pin,
  input wire        safing_fet_rail,
  input wire        safing_fet_on,
  input wire [15:0] loop_enable,
  input wire        disposal_arming
);
  reg [7:0]  stuck_r;
  reg [31:0] kidle_r;
  reg        line_r;
  wire [3:0] loops = loop_enable[3:0] | loop_enable[7:4] | loop_enable[11:8] | loop_enable[15:12];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // line stuck and key idle counters
  always @(posedge core_clk)
  begin
    line_r  <= disposal_line;
    stuck_r <= (!rstn || disposal_line != line_r) ? 8'h00 : stuck_r + {7'h0, stuck_r != 8'hFF};
    kidle_r <= (!rstn || (psel & penable & pwrite & paddr == 12'h024)) ? 32'h0 : kidle_r + 32'h1;
  end
  // ==========================================
  // properties
  fet_needs_host_a: assert property (safing_fet_on |-> $past(safing_fet_rail) && $past(host_fet_req))
    else $error("fet on without rail and host request");
  disp_all_on_a: assert property ($rose(disposal_arming) |-> ##[0:1] (arm_output_pin == 4'hF && safing_fet_rail))
    else $error("disposal arming without all outputs");
  sreset_disarm_a: assert property (!safing_reset_n [*3] |-> !disposal_arming)
    else $error("disposal arming through safing reset");
  loop_mask_sub_a: assert property ((loops & ~arm_output_pin) == 4'h0)
    else $error("loop enabled without its arm line");
  line_lost_a: assert property (int'(stuck_r) == 3 * PER_MAX + 8 |-> !disposal_arming)
    else $error("arming kept on a dead disposal line");
  key_late_a: assert property (kidle_r == TIMEOUT_CYC + 32'h8 |-> !disposal_arming)
    else $error("arming kept without key refresh");
  seed_width_a: assert property (psel && penable && !pwrite && paddr == 12'h020 |-> prdata[31:8] == 24'h0)
    else $error("seed wider than eight bits");
  arm_line_live_a: assert property ($rose(disposal_arming) |-> int'(stuck_r) <= PER_MAX)
    else $error("arming entered on a still line");
  arm_cov_c: cover property ($rose(disposal_arming));
  drop_cov_c: cover property ($fell(disposal_arming));
  fet_cov_c: cover property ($rose(safing_fet_on));
endmodule // sao_props
bind sao_top sao_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .PER_MAX(PER_MAX)) sao_props_inst (.core_clk, .rstn, .psel,
  .penable, .pwrite, .paddr, .prdata, .safing_reset_n, .host_fet_req, .disposal_line, .arm_output_pin,
  .safing_fet_rail, .safing_fet_on, .loop_enable, .disposal_arming);

/* File: sim/sao_host.sv */
// disposal line pwm source on the host side
`timescale 1ns/1ps
module sao_host #(
  parameter int PER = 16,
  parameter int ON  = 8
) (
  input wire    core_clk,
  input wire    en,
  output logic  disposal_line
);
  int cnt_r = 0;
  initial disposal_line = 1'b0;
  // line rests low while off
  always @(posedge core_clk)
  begin
    cnt_r         <= en ? (cnt_r + 1) % PER : 0;
    disposal_line <= en && cnt_r < ON;
  end
endmodule // sao_host

/* File: sim/sao_top_test.sv */
// self-checking bench for the safing arm output block
`timescale 1ns/1ps
module sao_top_test;
  logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        safing_reset_n = 1, host_fet_req = 0, pwm_en = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [3:0]  record_armed = 0, en, ln;
  logic [7:0]  map, kv;
  logic [15:0] mask;
  wire         pready, pslverr, disposal_line, safing_fet_rail, safing_fet_on, disposal_arming;
  wire [31:0]  prdata;
  wire [3:0]   arm_output_pin;
  wire [15:0]  loop_enable;
  int          err_total = 0, tests_run = 0, i, k;
  sao_top #(.SEED_DIV(16'h4), .TIMEOUT_CYC(32'hC8), .PER_MIN(24'h8), .PER_MAX(24'h20), .ON_MIN(24'h4))
    sao_top_inst (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .safing_reset_n, .record_armed, .host_fet_req, .disposal_line, .arm_output_pin,
    .safing_fet_rail, .safing_fet_on, .loop_enable, .disposal_arming);
  sao_host sao_host_inst (.core_clk, .en(pwm_en), .disposal_line);
  initial forever #4 core_clk = ~core_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic hs;
    apb(0, 12'h020, 0);
    kv = q[7:0] ^ 8'h55;
    apb(1, 12'h024, {24'h0, kv});
  endtask
  task automatic arm_up(input int gap);
    hs;
    cyc(gap);
    chk(disposal_arming, 0, "early arm");
    hs;
    for (k = 0; k < 400 && disposal_arming !== 1'b1; k++) @(posedge core_clk);
    cyc(1);
    chk({disposal_arming, arm_output_pin, safing_fet_rail}, 6'h3F, "arm");
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    $display("MISMATCH at %0t: watchdog", $time);
    finish_test;
  end
  initial
  begin
    k = $urandom(32'h3DED);
    cyc(4);
    rstn <= 1;
    apb(0, 12'h0FC, 0);
    chk(q, 0, "unmapped");
    for (i = 0; i < 12; i++)
    begin
      en = 4'($urandom);
      map = 8'($urandom);
      mask = 16'($urandom);
      apb(1, 12'h000, {28'h0, en});
      apb(1, 12'h004, {24'h0, map});
      apb(1, 12'h014, {16'h0, mask});
      record_armed <= 4'($urandom);
      host_fet_req <= 1'($urandom);
      cyc(4);
      ln = 0;
      for (k = 0; k < 4; k++)
        if (en[k] && record_armed[k])
          ln[map[2*k+:2]] = 1;
      chk(arm_output_pin, ln, "pins");
      chk({safing_fet_rail, safing_fet_on}, {|ln, |ln & host_fet_req}, "rail");
      for (k = 0; k < 4; k++)
        chk(loop_enable[4*k+:4], ln & ~mask[4*k+:4], "loop");
    end
    record_armed <= 0;
    $display("test map done");
    apb(1, 12'h004, 0);
    apb(1, 12'h008, 32'h1405);
    apb(1, 12'h000, 32'hF);
    record_armed <= 4'h3;
    cyc(1);
    record_armed <= 4'h0;
    cyc(4);
    record_armed <= 4'h1;
    cyc(1);
    record_armed <= 4'h0;
    apb(1, 12'h000, 0);
    apb(0, 12'h01C, 0);
    chk({q[31:8], |q[7:0]}, 25'h1, "stat");
    chk(arm_output_pin, 4'h1, "held");
    cyc(14);
    chk(arm_output_pin, 4'h0, "end");
    apb(1, 12'h000, 32'hF);
    record_armed <= 4'h2;
    cyc(1);
    record_armed <= 4'h0;
    safing_reset_n <= 0;
    cyc(4);
    chk(arm_output_pin, 0, "cut");
    safing_reset_n <= 1;
    apb(0, 12'h000, 0);
    chk(q, 0, "clear");
    $display("test stretch done");
    apb(1, 12'h018, 32'h7);
    cyc(2);
    chk({arm_output_pin, safing_fet_rail}, 5'h1E, "arm test");
    apb(0, 12'h018, 0);
    chk(q, 32'h5, "diag kept");
    apb(1, 12'h018, 32'h6);
    cyc(2);
    chk({arm_output_pin, safing_fet_rail}, 5'h01, "rail test");
    apb(1, 12'h018, 0);
    $display("test diag done");
    pwm_en <= 1;
    arm_up(80);
    for (i = 0; i < 3; i++)
    begin
      cyc(120);
      apb(1, 12'h024, {24'h0, kv});
    end
    chk(disposal_arming, 1, "kept");
    apb(1, 12'h024, {24'h0, kv ^ 8'h01});
    cyc(3);
    chk({disposal_arming, arm_output_pin}, 0, "bad key");
    arm_up(1);
    cyc(210);
    chk(disposal_arming, 0, "late");
    arm_up(1);
    safing_reset_n <= 0;
    cyc(4);
    chk(disposal_arming, 0, "sreset");
    safing_reset_n <= 1;
    arm_up(1);
    pwm_en <= 0;
    cyc(100);
    apb(1, 12'h024, {24'h0, kv});
    cyc(40);
    chk(disposal_arming, 0, "line");
    $display("test disposal done");
    finish_test;
  end
endmodule // sao_top_test
